/* File: dv/smbus_host_model.sv */
// Behavioural two-wire bus master that drives the register port.
`timescale 1ns/1ps

module smbus_host_model (
  // Bus lines, pull high means the master pulls data low.
  output logic o_scl,
  output logic o_sda_pull,
  input wire logic i_sda
);
  initial
  begin
    o_scl = 1'b1;
    o_sda_pull = 1'b0;
  end

  // A START from idle, or a repeated START from a low clock.
  task automatic start();
    #7;
    if (o_scl === 1'b0)
    begin
      o_sda_pull = 1'b0;
      #20;
      o_scl = 1'b1;
      #20;
    end
    o_sda_pull = 1'b1;
    #20;
    o_scl = 1'b0;
    #20;
  endtask

  // The clock stays high afterwards, so both lines rest released.
  task automatic stop();
    o_sda_pull = 1'b1;
    #20;
    o_scl = 1'b1;
    #20;
    o_sda_pull = 1'b0;
    #40;
  endtask

  // One clock: a 1 releases the line, which is sampled in mid high phase.
  task automatic bit_x(input logic b, output logic r);
    o_sda_pull = !b;
    #20;
    o_scl = 1'b1;
    #20;
    r = i_sda;
    #20;
    o_scl = 1'b0;
    #20;
  endtask

  // Eight bits MSB first, then the acknowledge slot.
  task automatic xbyte(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
    output logic ak);
    for (int i = 7; i >= 0; i--)
      bit_x(tx[i], rx[i]);
    bit_x(!mack, ak);
  endtask
endmodule

/* File: dv/tb_smbus_register_port_with_alert.sv */
// Self-checking bench for the two-wire register port with alert.
`timescale 1ns/1ps

module tb_smbus_register_port_with_alert;
  logic clk, rst_n, cause, pd, int_n, wr, clr;
  logic [3:0] pins;
  logic [4:0] raddr;
  logic [7:0] evs, wdata, rdata;
  logic [7:0] core [32];
  logic [7:0] mdl [32];
  logic [7:0] exp_a [$];
  logic [7:0] exp_d [$];
  int fail_count, cmp_count, clr_seen;
  wire scl, mpull, sda;

  // Open-drain data wire with a pull-up.
  assign sda = !(mpull | pd);
  assign rdata = core[raddr];

  smbus_host_model mst (.o_scl(scl), .o_sda_pull(mpull), .i_sda(sda));
  smbus_register_port_with_alert dut (.i_sys_clk(clk), .i_arst_n(rst_n), .i_scl(scl),
    .i_serial_data_input(sda), .o_serial_data_pulldown(pd), .i_address_select_pins(pins),
    .o_int_n(int_n), .i_event_summary(evs), .i_reg_rdata(rdata), .i_int_cause(cause),
    .o_reg_addr(raddr), .o_reg_wdata(wdata), .o_reg_wr_pulse(wr), .o_clear_all(clr));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // The core model takes every write and compares it with the expected queue.
  always @(posedge clk)
  begin
    if (wr === 1'b1)
    begin
      if (exp_a.size() == 0)
        chk("spurious write", 8'h00, 8'h01);
      else
      begin
        chk("write addr", exp_a.pop_front(), {3'h0, raddr});
        chk("write data", exp_d.pop_front(), wdata);
      end
      core[raddr] <= wdata;
    end
    if (clr === 1'b1)
      clr_seen++;
  end

  task automatic gap(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic int_is(input string n, input logic e);
    for (int i = 0; i < 20 && int_n !== e; i++)
      @(posedge clk);
    chk(n, {7'h0, e}, {7'h0, int_n});
  endtask

  task automatic wr_frame(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
    output logic [2:0] ak);
    logic [7:0] rx;
    mst.start();
    mst.xbyte({a, 1'b0}, 1'b0, rx, ak[2]);
    mst.xbyte(c, 1'b0, rx, ak[1]);
    mst.xbyte(d, 1'b0, rx, ak[0]);
    mst.stop();
    gap(10);
  endtask

  task automatic rd_frame(input logic [6:0] a, input logic [7:0] c, output logic [7:0] rx,
    output logic [2:0] ak);
    logic nk;
    mst.start();
    mst.xbyte({a, 1'b0}, 1'b0, rx, ak[2]);
    mst.xbyte(c, 1'b0, rx, ak[1]);
    mst.start();
    mst.xbyte({a, 1'b1}, 1'b0, rx, ak[0]);
    mst.xbyte(8'hff, 1'b0, rx, nk);
    mst.stop();
    gap(10);
  endtask

  // Zeros in tx stand for a rival device on the line.
  task automatic rcv_frame(input logic [6:0] a, input logic [7:0] tx, output logic [7:0] rx,
    output logic ak);
    logic nk;
    mst.start();
    mst.xbyte({a, 1'b1}, 1'b0, rx, ak);
    mst.xbyte(tx, 1'b0, rx, nk);
    mst.stop();
    gap(10);
  endtask

  initial
  begin
    #300000;
    fail_count++;
    conclude();
  end

  initial
  begin
    logic [2:0] ak;
    logic [7:0] rx, d;
    logic a1;
    logic [6:0] own;
    logic [4:0] p;
    rst_n = 1'b0;
    cause = 1'b0;
    pins = 4'h5;
    evs = 8'h00;
    fail_count = 0;
    cmp_count = 0;
    clr_seen = 0;
    void'($urandom(52));
    foreach (core[i])
      core[i] = 8'($urandom);
    own = {smbus_port_pkg::OWN_ADDR_HI, pins};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    evs <= 8'($urandom);
    gap(6);
    for (int k = 0; k < 3; k++)
    begin
      p = 5'($urandom_range(1, 25));
      d = 8'($urandom);
      mdl[p] = d;
      exp_a.push_back({3'h0, p});
      exp_d.push_back(d);
      wr_frame(own, {3'($urandom), p}, d, ak);
      chk("write acks", 8'h00, {5'h0, ak});
      rd_frame(own, {3'h0, p}, rx, ak);
      chk("read acks", 8'h00, {5'h0, ak});
      chk("read data", mdl[p], rx);
    end
    rcv_frame(own, 8'hff, rx, a1);
    chk("receive data", evs, rx);
    $display("test write read receive done");
    d = 8'($urandom);
    exp_a.push_back(8'h03);
    exp_d.push_back(d);
    wr_frame(smbus_port_pkg::GLOBAL_ADDR, 8'h03, d, ak);
    chk("global acks", 8'h00, {5'h0, ak});
    rcv_frame(smbus_port_pkg::GLOBAL_ADDR, 8'hff, rx, a1);
    chk("global read ack", 8'h01, {7'h0, a1});
    wr_frame(own ^ 7'h01, 8'h04, 8'h55, ak);
    chk("foreign acks", 8'h07, {5'h0, ak});
    rcv_frame(smbus_port_pkg::ALERT_RESP_ADDR, 8'hff, rx, a1);
    chk("idle alert ack", 8'h01, {7'h0, a1});
    $display("test addressing done");
    mst.start();
    mst.xbyte({own, 1'b0}, 1'b0, rx, a1);
    @(posedge clk);
    cause <= 1'b1;
    gap(20);
    chk("int in frame", 8'h01, {7'h0, int_n});
    mst.stop();
    int_is("int after stop", 1'b0);
    $display("test interrupt hold done");
    rcv_frame(smbus_port_pkg::ALERT_RESP_ADDR, {own, 1'b1} & 8'hfd, rx, a1);
    chk("lost alert data", {own, 1'b1} & 8'hfd, rx);
    gap(20);
    chk("int after loss", 8'h00, {7'h0, int_n});
    rcv_frame(smbus_port_pkg::ALERT_RESP_ADDR, 8'hff, rx, a1);
    chk("alert ack", 8'h00, {7'h0, a1});
    chk("alert data", {own, 1'b1}, rx);
    int_is("int after win", 1'b1);
    gap(20);
    chk("int masked", 8'h01, {7'h0, int_n});
    rcv_frame(smbus_port_pkg::ALERT_RESP_ADDR, 8'hff, rx, a1);
    chk("released alert ack", 8'h01, {7'h0, a1});
    $display("test alert response done");
    @(posedge clk);
    cause <= 1'b0;
    gap(5);
    cause <= 1'b1;
    int_is("int new cause", 1'b0);
    exp_a.push_back(8'h1a);
    exp_d.push_back(8'h40);
    wr_frame(own, 8'hfa, 8'h40, ak);
    int_is("int release bit", 1'b1);
    exp_a.push_back(8'h1a);
    exp_d.push_back(8'h80);
    wr_frame(own, 8'h1a, 8'h80, ak);
    int_is("int after clear all", 1'b0);
    chk("clear all pulses", 8'h01, 8'(clr_seen));
    chk("writes left", 8'h00, 8'(exp_a.size()));
    $display("test release and clear done");
    conclude();
  end
endmodule

/* File: verilog/smbus_port_pkg.sv */
// Constants shared by the two-wire register port with alert.
package smbus_port_pkg;

  // Bus field widths.
  localparam int ADDR_W = 7;
  localparam int PTR_W = 5;
  localparam int BYTE_W = 8;
  localparam int SEL_W = 4;

  // Slave addresses.
  localparam logic [2:0] OWN_ADDR_HI = 3'h2;
  localparam logic [6:0] GLOBAL_ADDR = 7'h30;
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;

  // Register pointer values.
  localparam logic [4:0] REG_EVENT_SUMMARY = 5'h00;
  localparam logic [4:0] REG_INT_CLEAR_CONTROL = 5'h1a;
  localparam logic [4:0] PTR_RESET = 5'h00;

  // Bit positions inside the interrupt clear control register.
  localparam int BIT_RELEASE_INT = 6;
  localparam int BIT_CLEAR_ALL = 7;

  // Bit counter values within one nine-clock byte slot.
  localparam logic [3:0] CNT_FIRST = 4'h1;
  localparam logic [3:0] CNT_LAST_DATA = 4'h7;
  localparam logic [3:0] CNT_ACK = 4'h8;
  localparam logic [3:0] CNT_ZERO = 4'h0;

  // Reset values.
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Link state machine.
  typedef enum logic [5:0] {
    ST_IGNORE = 6'h01,
    ST_ADDR = 6'h02,
    ST_CMD = 6'h04,
    ST_WDATA = 6'h08,
    ST_READ = 6'h10,
    ST_ALERT = 6'h20
  } link_state_e;

endpackage

/* File: verilog/smbus_register_port_with_alert.sv */
// Two-wire slave register port with alert response and interrupt line.
//
// Functional notes
// - Interrupt output changes only between transactions; START holds it until STOP.
// - Data line has separate sample input and pull-down output pins.
// - Supports Write Byte, Read Byte and Receive Byte transfers only.
// - Own address is 010 followed by the four address select pins.
// - Global write address 0110000 is also accepted.
// - Alert response address 0001100 acknowledged only while interrupt is low.
// - START is data falling with clock high; STOP is data rising with clock high.
// - Receiver holds data low through the high phase of the acknowledge clock.
// - Command byte is acknowledged and its low five bits load the pointer.
// - Write Byte data is acknowledged and written to the pointed register.
// - The first START after a STOP clears the register pointer to zero.
// - Read Byte returns the pointed register after repeated START with read bit.
// - Receive Byte returns the event summary register at pointer zero.
// - Alert response sends own seven-bit address followed by a one.
// - Alert response send aborts at once when a driven one reads back zero.
// - Winning the alert response releases the interrupt line.
// - Release by alert response or control bit six masks until cause removed.
// - Cause removed by clearing events or writing control bit seven.
`timescale 1ns/1ps

module smbus_register_port_with_alert (
  // System clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  // Two-wire bus.
  input wire logic i_scl,
  input wire logic i_serial_data_input,
  output logic o_serial_data_pulldown,
  input wire logic [3:0] i_address_select_pins,
  // Interrupt line, low while asserted.
  output logic o_int_n,
  // Register file of the device core.
  input wire logic [7:0] i_event_summary,
  input wire logic [7:0] i_reg_rdata,
  input wire logic i_int_cause,
  output logic [4:0] o_reg_addr,
  output logic [7:0] o_reg_wdata,
  output logic o_reg_wr_pulse,
  output logic o_clear_all
);

  // Condition detectors clocked by the data line itself.
  logic start_tog;
  logic stop_tog;

  always_ff @(negedge i_serial_data_input or negedge i_arst_n)
  begin
    if (!i_arst_n)
      start_tog <= 1'b0;
    else if (i_scl)
      start_tog <= ~start_tog;
  end

  always_ff @(posedge i_serial_data_input or negedge i_arst_n)
  begin
    if (!i_arst_n)
      stop_tog <= 1'b0;
    else if (i_scl)
      stop_tog <= ~stop_tog;
  end

  // Link domain, clocked by the bus clock.
  smbus_port_pkg::link_state_e state;
  smbus_port_pkg::link_state_e after_ack;
  smbus_port_pkg::link_state_e next_state;
  smbus_port_pkg::link_state_e next_after;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [6:0] shift;
  logic [7:0] tx;
  logic [7:0] wr_data;
  logic [4:0] pointer;
  logic start_ack;
  logic stop_ack;
  logic ack_flag;
  logic next_ack;
  logic ptr_tog;
  logic wr_tog;
  logic ara_tog;
  logic [3:0] sel_s1;
  logic [3:0] sel_s2;
  logic int_low_s1;
  logic int_low_s2;
  logic [7:0] rd_byte;

  // Start and stop toggles change while the clock is high, well before the
  // next rising edge, so the link domain reads them directly.
  wire frame_start = start_tog != start_ack;
  wire stop_pend = stop_tog != stop_ack;
  wire [7:0] rx_byte = {shift, i_serial_data_input};
  wire [6:0] own_addr = {smbus_port_pkg::OWN_ADDR_HI, sel_s2};
  wire rx_rw = rx_byte[0];
  wire hit_own = rx_byte[7:1] == own_addr;
  wire hit_gen = (rx_byte[7:1] == smbus_port_pkg::GLOBAL_ADDR) && !rx_rw;
  wire hit_ara = (rx_byte[7:1] == smbus_port_pkg::ALERT_RESP_ADDR) && rx_rw && int_low_s2;
  wire at_last = cnt == smbus_port_pkg::CNT_LAST_DATA;
  wire at_ack = cnt == smbus_port_pkg::CNT_ACK;
  wire in_data = cnt <= smbus_port_pkg::CNT_LAST_DATA;
  wire tx_active = (state == smbus_port_pkg::ST_READ || state == smbus_port_pkg::ST_ALERT)
                   && in_data;
  wire arb_lost = (state == smbus_port_pkg::ST_ALERT) && in_data && tx[7]
                  && !i_serial_data_input;
  wire ara_done = (state == smbus_port_pkg::ST_ALERT) && at_last && !arb_lost;
  wire cmd_done = (state == smbus_port_pkg::ST_CMD) && at_last && !frame_start;
  wire wr_done = (state == smbus_port_pkg::ST_WDATA) && at_last && !frame_start;
  wire ptr_clear = frame_start && stop_pend;
  wire [7:0] ara_byte = {own_addr, 1'b1};

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_after = after_ack;
    next_ack = ack_flag;
    if (frame_start)
    begin
      next_state = smbus_port_pkg::ST_ADDR;
      next_cnt = smbus_port_pkg::CNT_FIRST;
      next_ack = 1'b0;
    end
    else if (arb_lost)
    begin
      next_state = smbus_port_pkg::ST_IGNORE;
      next_cnt = 4'(cnt + 4'h1);
    end
    else if (cnt < smbus_port_pkg::CNT_LAST_DATA)
      next_cnt = 4'(cnt + 4'h1);
    else if (at_last)
    begin
      next_cnt = smbus_port_pkg::CNT_ACK;
      next_ack = 1'b0;
      next_after = smbus_port_pkg::ST_IGNORE;
      unique case (state)
        smbus_port_pkg::ST_ADDR:
        begin
          next_ack = hit_own || hit_gen || hit_ara;
          if (hit_ara)
            next_after = smbus_port_pkg::ST_ALERT;
          else if (hit_own && rx_rw)
            next_after = smbus_port_pkg::ST_READ;
          else if (hit_own || hit_gen)
            next_after = smbus_port_pkg::ST_CMD;
        end
        smbus_port_pkg::ST_CMD:
        begin
          next_ack = 1'b1;
          next_after = smbus_port_pkg::ST_WDATA;
        end
        smbus_port_pkg::ST_WDATA:
          next_ack = 1'b1;
        smbus_port_pkg::ST_READ:
          next_after = smbus_port_pkg::ST_READ;
        smbus_port_pkg::ST_ALERT,
        smbus_port_pkg::ST_IGNORE:
          next_after = smbus_port_pkg::ST_IGNORE;
      endcase
    end
    else
    begin
      next_cnt = smbus_port_pkg::CNT_ZERO;
      next_ack = 1'b0;
      next_state = after_ack;
      // A read stops at the master's missing acknowledge.
      if (after_ack == smbus_port_pkg::ST_READ && i_serial_data_input)
        next_state = smbus_port_pkg::ST_IGNORE;
    end
  end

  always_ff @(posedge i_scl or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state <= smbus_port_pkg::ST_IGNORE;
      after_ack <= smbus_port_pkg::ST_IGNORE;
      cnt <= smbus_port_pkg::CNT_ZERO;
      ack_flag <= 1'b0;
      shift <= 7'h00;
      start_ack <= 1'b0;
      stop_ack <= 1'b0;
    end
    else
    begin
      state <= next_state;
      after_ack <= next_after;
      cnt <= next_cnt;
      ack_flag <= next_ack;
      shift <= frame_start ? {6'h00, i_serial_data_input} : rx_byte[6:0];
      start_ack <= start_tog;
      stop_ack <= frame_start ? stop_tog : stop_ack;
    end
  end

  // Pointer survives a repeated start and is cleared by the first start after a stop.
  always_ff @(posedge i_scl or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pointer <= smbus_port_pkg::PTR_RESET;
      ptr_tog <= 1'b0;
    end
    else if (ptr_clear)
    begin
      pointer <= smbus_port_pkg::PTR_RESET;
      ptr_tog <= ~ptr_tog;
    end
    else if (cmd_done)
    begin
      pointer <= rx_byte[smbus_port_pkg::PTR_W-1:0];
      ptr_tog <= ~ptr_tog;
    end
  end

  always_ff @(posedge i_scl or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wr_data <= smbus_port_pkg::BYTE_RESET;
      wr_tog <= 1'b0;
      ara_tog <= 1'b0;
    end
    else
    begin
      wr_data <= wr_done ? rx_byte : wr_data;
      wr_tog <= wr_tog ^ wr_done;
      ara_tog <= ara_tog ^ ara_done;
    end
  end

  // The read byte is loaded at the acknowledge clock; it was settled from the
  // pointer many system clocks earlier, so it is stable when sampled here.
  always_ff @(posedge i_scl or negedge i_arst_n)
  begin
    if (!i_arst_n)
      tx <= smbus_port_pkg::BYTE_RESET;
    else if (at_ack && next_state == smbus_port_pkg::ST_ALERT)
      tx <= ara_byte;
    else if (at_ack && next_state == smbus_port_pkg::ST_READ)
      tx <= rd_byte;
    else if (tx_active)
      tx <= {tx[6:0], 1'b0};
  end

  always_ff @(posedge i_scl or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sel_s1 <= 4'h0;
      sel_s2 <= 4'h0;
      int_low_s1 <= 1'b0;
      int_low_s2 <= 1'b0;
    end
    else
    begin
      sel_s1 <= i_address_select_pins;
      sel_s2 <= sel_s1;
      int_low_s1 <= ~o_int_n;
      int_low_s2 <= int_low_s1;
    end
  end

  // Data is changed only while the clock is low.
  wire next_pulldown = !frame_start && ((at_ack && ack_flag) || (tx_active && !tx[7]));

  always_ff @(negedge i_scl or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_serial_data_pulldown <= 1'b0;
    else
      o_serial_data_pulldown <= next_pulldown;
  end

  // System domain: every link toggle passes two flip-flops, a third gives edges.
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] sync3;
  logic busy;
  logic rel;

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
      sync3 <= 5'h00;
    end
    else
    begin
      sync1 <= {ara_tog, wr_tog, ptr_tog, stop_tog, start_tog};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  wire [4:0] tog_edge = sync2 ^ sync3;
  wire start_edge = tog_edge[0];
  wire stop_edge = tog_edge[1];
  wire ptr_edge = tog_edge[2];
  wire wr_edge = tog_edge[3];
  wire ara_edge = tog_edge[4];
  wire ctl_hit = wr_edge && (o_reg_addr == smbus_port_pkg::REG_INT_CLEAR_CONTROL);
  wire rel_req = ara_edge || (ctl_hit && wr_data[smbus_port_pkg::BIT_RELEASE_INT]);
  wire clr_req = ctl_hit && wr_data[smbus_port_pkg::BIT_CLEAR_ALL];
  wire next_rel = rel_req ? 1'b1 : ((!i_int_cause || o_clear_all) ? 1'b0 : rel);
  wire pending = i_int_cause && !rel;
  wire next_busy = stop_edge ? 1'b0 : (start_edge ? 1'b1 : busy);
  wire [7:0] next_rd = (o_reg_addr == smbus_port_pkg::REG_EVENT_SUMMARY) ? i_event_summary
                       : i_reg_rdata;

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      busy <= 1'b0;
      rel <= 1'b0;
      o_int_n <= 1'b1;
    end
    else
    begin
      busy <= next_busy;
      rel <= next_rel;
      o_int_n <= busy ? o_int_n : !pending;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_reg_addr <= smbus_port_pkg::PTR_RESET;
      o_reg_wdata <= smbus_port_pkg::BYTE_RESET;
      o_reg_wr_pulse <= 1'b0;
      o_clear_all <= 1'b0;
      rd_byte <= smbus_port_pkg::BYTE_RESET;
    end
    else
    begin
      o_reg_addr <= ptr_edge ? pointer : o_reg_addr;
      o_reg_wdata <= wr_edge ? wr_data : o_reg_wdata;
      o_reg_wr_pulse <= wr_edge;
      o_clear_all <= clr_req;
      rd_byte <= next_rd;
    end
  end

  // Checks in the system domain.
  a_int_bus_hold: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    $past(busy) |-> $stable(o_int_n))
    else $error("interrupt line changed during a transaction");
  a_write_pulse: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    wr_edge |=> o_reg_wr_pulse && o_reg_wdata == $past(wr_data) ##1 !o_reg_wr_pulse)
    else $error("register write pulse wrong");
  a_release_masks: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (rel && !busy) |=> o_int_n)
    else $error("released interrupt still asserted");
  a_clear_all_bit: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    clr_req |=> o_clear_all ##1 !rel)
    else $error("clear all did not act");
  a_alert_release: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    ara_edge |=> rel)
    else $error("alert response win did not release interrupt");
  // Checks in the link domain.
  a_ptr_low_bits: assert property (@(posedge i_scl) disable iff (!i_arst_n)
    cmd_done |=> pointer == $past(rx_byte[4:0]) && ack_flag)
    else $error("pointer not loaded from command byte");
  a_stop_clears_ptr: assert property (@(posedge i_scl) disable iff (!i_arst_n)
    ptr_clear |=> pointer == smbus_port_pkg::PTR_RESET)
    else $error("stop did not clear pointer");
  a_ack_held_low: assert property (@(posedge i_scl) disable iff (!i_arst_n)
    (at_ack && ack_flag) |-> o_serial_data_pulldown)
    else $error("acknowledge not driven low");
  a_own_addr_ack: assert property (@(posedge i_scl) disable iff (!i_arst_n)
    (state == smbus_port_pkg::ST_ADDR && at_last && !frame_start && hit_own) |=> ack_flag)
    else $error("own address not acknowledged");
  a_arb_abort: assert property (@(posedge i_scl) disable iff (!i_arst_n)
    (arb_lost && !frame_start) |=> state == smbus_port_pkg::ST_IGNORE
      ##1 !o_serial_data_pulldown)
    else $error("lost arbitration but kept sending");
  a_alert_needs_int: assert property (@(posedge i_scl) disable iff (!i_arst_n)
    (state == smbus_port_pkg::ST_ALERT && cnt == smbus_port_pkg::CNT_ZERO)
      |-> $past(int_low_s2, 2))
    else $error("alert response answered without interrupt");
  c_write_byte: cover property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    o_reg_wr_pulse);
  c_read_byte: cover property (@(posedge i_scl) disable iff (!i_arst_n)
    state == smbus_port_pkg::ST_READ && at_last);
  c_alert_win: cover property (@(posedge i_scl) disable iff (!i_arst_n)
    ara_done);
  c_alert_lost: cover property (@(posedge i_scl) disable iff (!i_arst_n)
    arb_lost);

endmodule
